/* logic/pm1_event_status_pkg.sv */
package pm1_event_status_pkg;

   // status bit positions, identical in both register blocks
   localparam int unsigned TIMER_CARRY_BIT  = 0;
   localparam int unsigned BUS_MASTER_BIT   = 4;
   localparam int unsigned GLOBAL_LOCK_BIT  = 5;

   // register width and reset value
   localparam int unsigned STATUS_WIDTH     = 16;
   localparam logic [15:0] STATUS_RESET     = 16'h0000;

   // every bit this bank can ever hold (bits 0, 4 and 5)
   localparam logic [15:0] STATUS_IMPL_ALL  = 16'h0031;

   // byte offsets of the status register inside a block
   localparam logic [1:0]  STATUS_LOW_OFFSET  = 2'h0;
   localparam logic [1:0]  STATUS_HIGH_OFFSET = 2'h1;

   // lane masks for byte and word accesses
   localparam logic [15:0] LANE_LOW         = 16'h00ff;
   localparam logic [15:0] LANE_HIGH        = 16'hff00;
   localparam logic [15:0] LANE_WORD        = 16'hffff;

   // block base alignment: low address bits ignored
   localparam int unsigned BLOCK_ALIGN_BITS = 2;

   // documented counter widths
   localparam int unsigned COUNTER_SHORT    = 24;
   localparam int unsigned COUNTER_LONG     = 32;

   // one system i/o request, as presented by the host side
   typedef struct packed {
      logic        rd;      // read strobe, one cycle
      logic        wr;      // write strobe, one cycle
      logic        word;    // 1: 16-bit access, 0: byte access
      logic [15:0] addr;    // i/o byte address
      logic [15:0] wdata;   // byte data sits in [7:0]
   } io_req_type;

endpackage : pm1_event_status_pkg

/* logic/pm1_event_status_bank.sv */
`timescale 1ns/1ps
module pm1_event_status_bank
   import pm1_event_status_pkg::*;
#(
   parameter int unsigned COUNTER_WIDTH  = COUNTER_SHORT,
   parameter logic [15:0] PRIMARY_MASK   = STATUS_IMPL_ALL,
   parameter logic [15:0] SECONDARY_MASK = 16'h0000
)
(
   input  wire logic                     core_clk,
   input  wire logic                     resetn,
   input  wire io_req_type               io_req,
   output logic                          io_ack,
   output logic [15:0]                   io_rdata,
   input  wire logic [15:0]              primary_event_block_pointer,
   input  wire logic [15:0]              secondary_event_block_pointer,
   input  wire logic [COUNTER_WIDTH-1:0] pm_counter,
   input  wire logic                     timer_carry_irq_enable,
   input  wire logic                     global_irq_enable,
   input  wire logic                     bus_master_req,
   input  wire logic                     fw_attention,
   input  wire logic                     fw_lock_release,
   input  wire logic                     fw_lock_pending,
   input  wire logic                     enter_working_state,
   output logic                          system_control_irq
);

   ////////////////////////////////////////////////////////////////////
   // elaboration checks

   // counter must be one of the two documented widths
   if (COUNTER_WIDTH != COUNTER_SHORT && COUNTER_WIDTH != COUNTER_LONG)
   begin : g_bad_width
      $error("counter width must be 24 or 32");
   end

   // a bit lives in one block only, and only where logic exists
   if ((PRIMARY_MASK & SECONDARY_MASK) != 16'h0000 ||
       ((PRIMARY_MASK | SECONDARY_MASK) & ~STATUS_IMPL_ALL) != 16'h0000)
   begin : g_bad_mask
      $error("block masks overlap or name unbuilt bits");
   end

   ////////////////////////////////////////////////////////////////////
   // declarations

   logic [15:0] flags;          // status bits, shared positions
   logic [15:0] next_flags;     // next status value
   logic [15:0] blk_mask_q;     // block mask of the previous cycle
   logic [15:0] set_bits;       // hardware set requests
   logic [15:0] clr_bits;       // software and entry clears
   logic        bm_sync1;       // bus request, first stage
   logic        bm_sync2;       // bus request, second stage
   logic        msb_prev;       // counter msb last cycle
   logic        msb_primed;     // msb_prev holds a real sample
   wire  logic  msb_now;        // counter msb this cycle
   wire  logic  msb_toggle;     // msb changed either way
   wire  logic  hit_a;          // access decodes to primary block
   wire  logic  hit_b;          // access decodes to secondary block
   wire  logic  size_ok;        // legal size and offset
   wire  logic  hit;            // access is ours
   wire  logic [1:0]  offset;   // byte offset inside the block
   wire  logic [15:0] blk_mask; // bits of the addressed block
   wire  logic [15:0] lane;     // byte lanes touched
   wire  logic [15:0] wpos;     // write data moved onto its lanes
   wire  logic [15:0] w1c;      // write-one-clear bits
   wire  logic [15:0] rview;    // addressed block as seen
   wire  logic [15:0] rsel;     // read data placed for the size

   ////////////////////////////////////////////////////////////////////
   // address decode

   assign offset = io_req.addr[BLOCK_ALIGN_BITS-1:0];

   assign hit_a = io_req.addr[15:BLOCK_ALIGN_BITS] ==
                  primary_event_block_pointer[15:BLOCK_ALIGN_BITS];
   assign hit_b = io_req.addr[15:BLOCK_ALIGN_BITS] ==
                  secondary_event_block_pointer[15:BLOCK_ALIGN_BITS];

   // byte at offset 0/1, word at 0
   assign size_ok = io_req.word ? (offset == STATUS_LOW_OFFSET)
                                : (offset == STATUS_LOW_OFFSET ||
                                   offset == STATUS_HIGH_OFFSET);

   assign hit = (hit_a || hit_b) && size_ok;

   // same positions, primary wins a shared base
   assign blk_mask = hit_a ? PRIMARY_MASK : SECONDARY_MASK;

   ////////////////////////////////////////////////////////////////////
   // write path

   // lanes touched by this access
   assign lane = io_req.word ? LANE_WORD
               : (offset == STATUS_HIGH_OFFSET) ? LANE_HIGH : LANE_LOW;

   // byte data is replicated onto both lanes
   assign wpos = io_req.word ? io_req.wdata
                             : {io_req.wdata[7:0], io_req.wdata[7:0]};

   // foreign bits masked out of the clear
   assign w1c = (io_req.wr && hit) ? (wpos & lane & blk_mask) : 16'h0000;

   ////////////////////////////////////////////////////////////////////
   // read path

   // only this block's bits are visible
   assign rview = flags & blk_mask;

   // byte reads return their lane in the low byte
   assign rsel = io_req.word ? rview
               : (offset == STATUS_HIGH_OFFSET) ? {8'h00, rview[15:8]}
               : {8'h00, rview[7:0]};

   ////////////////////////////////////////////////////////////////////
   // event sources

   assign msb_now = pm_counter[COUNTER_WIDTH-1];

   assign msb_toggle = msb_primed && (msb_now != msb_prev);

   // hardware set requests per bit
   always_comb
   begin
      set_bits = 16'h0000;
      set_bits[TIMER_CARRY_BIT] = msb_toggle;
      set_bits[BUS_MASTER_BIT]  = bm_sync2;
      // attention or lock release seen pending
      set_bits[GLOBAL_LOCK_BIT] = fw_attention ||
                                  (fw_lock_release && fw_lock_pending);
   end

   // entry to working state clears all
   assign clr_bits = w1c | (enter_working_state ? LANE_WORD : 16'h0000);

   // set wins over a same-cycle clear
   assign next_flags = (set_bits | (flags & ~clr_bits)) & STATUS_IMPL_ALL;

   ////////////////////////////////////////////////////////////////////
   // status flags

   // status register update
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         flags <= STATUS_RESET;
      else
         flags <= next_flags;
   end

   // bus request synchroniser, two stages
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bm_sync1 <= 1'b0;
         bm_sync2 <= 1'b0;
      end
      else
      begin
         bm_sync1 <= bus_master_req;
         bm_sync2 <= bm_sync1;
      end
   end

   // counter msb history; first sample only primes
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         msb_prev   <= 1'b0;
         msb_primed <= 1'b0;
      end
      else
      begin
         msb_prev   <= msb_now;
         msb_primed <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus answer

   // ack one cycle after an accepted access
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         io_ack   <= 1'b0;
         io_rdata <= 16'h0000;
      end
      else
      begin
         io_ack   <= (io_req.rd || io_req.wr) && hit;
         io_rdata <= (io_req.rd && hit) ? rsel : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupt

   assign system_control_irq =
      (flags[TIMER_CARRY_BIT] && timer_carry_irq_enable) ||
      (flags[GLOBAL_LOCK_BIT] && global_irq_enable);

   ////////////////////////////////////////////////////////////////////
   // assertions

   // counter msb flips in either direction
   sequence s_msb_flip;
      msb_primed && (msb_now != msb_prev);
   endsequence

   // a legal access lands in one of the blocks
   sequence s_legal_access;
      (io_req.rd || io_req.wr) && size_ok && (hit_a || hit_b);
   endsequence

   // bus request crosses both stages
   sequence s_bm_request;
      bus_master_req;
   endsequence

   a_timer_carry_set: assert property (
      @(posedge core_clk) disable iff (!resetn)
      s_msb_flip |=> flags[TIMER_CARRY_BIT])
      else $error("timer flag missed an msb change");

   a_timer_irq_level: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (flags[TIMER_CARRY_BIT] && timer_carry_irq_enable)
      |-> system_control_irq)
      else $error("timer interrupt not raised");

   a_bus_master_set: assert property (
      @(posedge core_clk) disable iff (!resetn)
      s_bm_request |-> ##3 flags[BUS_MASTER_BIT])
      else $error("bus master flag not set");

   a_bus_master_hold: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (flags[BUS_MASTER_BIT] && !clr_bits[BUS_MASTER_BIT])
      |=> flags[BUS_MASTER_BIT])
      else $error("bus master flag lost without a one");

   a_write_one_clear: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (w1c[TIMER_CARRY_BIT] && !msb_toggle)
      |=> !flags[TIMER_CARRY_BIT])
      else $error("timer flag survived write of one");

   a_attention_irq: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (fw_attention && global_irq_enable) ##1 global_irq_enable
      |-> flags[GLOBAL_LOCK_BIT] && system_control_irq)
      else $error("attention did not raise interrupt");

   a_lock_release_set: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (fw_lock_release && fw_lock_pending) |=> flags[GLOBAL_LOCK_BIT])
      else $error("global flag missed lock release");

   a_entry_clears_all: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (enter_working_state && set_bits == 16'h0000) |=> flags == 16'h0000)
      else $error("status not cleared on working entry");

   a_foreign_bits_zero: assert property (
      @(posedge core_clk) disable iff (!resetn)
      (io_req.rd && hit && io_req.word)
      |=> (io_rdata & ~blk_mask_q) == 16'h0000)
      else $error("foreign or reserved bit read nonzero");

   a_access_answer: assert property (
      @(posedge core_clk) disable iff (!resetn)
      s_legal_access |=> io_ack)
      else $error("legal access not answered");

   // block mask of the previous cycle, sampled every cycle, read only by an assertion
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         blk_mask_q <= 16'h0000;
      else
         blk_mask_q <= blk_mask;
   end

endmodule : pm1_event_status_bank

/* sim/pm1_host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// host software side: byte or word cycles in system i/o space
module pm1_host_model
   import pm1_event_status_pkg::*;
(
   input  wire logic        core_clk,
   output io_req_type       io_req,
   input  wire logic        io_ack,
   input  wire logic [15:0] io_rdata
);
   // idle bus, no strobe
   initial io_req = '0;

   // one access: strobe over one edge, answer taken the cycle after
   // byte or word sizes
   task automatic access(input logic rd, input logic wr,
      input logic word, input logic [15:0] addr,
      input logic [15:0] wdata, output logic ack,
      output logic [15:0] rdata);
      @(posedge core_clk);
      #1;
      io_req = '{rd: rd, wr: wr, word: word, addr: addr, wdata: wdata};
      @(posedge core_clk);
      #1;
      // released: qualifiers flip so stale values never look valid
      io_req = '{rd: 1'b0, wr: 1'b0, word: ~word, addr: ~addr,
                 wdata: ~wdata};
      ack = io_ack;
      rdata = io_rdata;
   endtask : access
endmodule : pm1_host_model

/* sim/pm1_event_status_bank_tb_top.sv */
`timescale 1ns/1ps
module pm1_event_status_bank_tb_top
   import pm1_event_status_pkg::*;
;
   localparam logic [15:0] PA = 16'h0400; // primary block base
   localparam logic [15:0] PB = 16'h0820; // secondary block base
   logic        core_clk = 1'b0;
   logic        resetn, io_ack, system_control_irq;
   io_req_type  io_req;
   logic [15:0] io_rdata;
   logic [23:0] pm_counter;
   logic        timer_carry_irq_enable, global_irq_enable;
   logic        bus_master_req, fw_attention, enter_working_state;
   logic        fw_lock_release, fw_lock_pending;
   int          n_errors = 0;
   int          checks_done = 0;
   // one read row: size, address, expected answer
   typedef struct packed
   {
      logic word; logic [15:0] addr; logic ack; logic [15:0] data;
   } row_type;
   row_type rows [9] = '{
      '{1'b1, PA, 1'b1, 16'h0011}, '{1'b0, PA, 1'b1, 16'h0011},
      '{1'b0, PA + 16'h0001, 1'b1, 16'h0000},
      '{1'b1, PA + 16'h0001, 1'b0, 16'h0000},
      '{1'b0, PA + 16'h0002, 1'b0, 16'h0000},
      '{1'b1, PB, 1'b1, 16'h0020}, '{1'b0, PB, 1'b1, 16'h0020},
      '{1'b1, PA + 16'h0004, 1'b0, 16'h0000},
      '{1'b1, PB + 16'h0003, 1'b0, 16'h0000}};

   ////////////////////////////////////////////////////////////////
   // clock, host model, design
   always #5 core_clk = ~core_clk;

   pm1_host_model i_pm1_host_model (.core_clk(core_clk),
      .io_req(io_req), .io_ack(io_ack), .io_rdata(io_rdata));

   pm1_event_status_bank #(.PRIMARY_MASK(16'h0011),
      .SECONDARY_MASK(16'h0020)) i_pm1_event_status_bank (
      .core_clk(core_clk), .resetn(resetn), .io_req(io_req),
      .io_ack(io_ack), .io_rdata(io_rdata),
      .primary_event_block_pointer(PA),
      .secondary_event_block_pointer(PB), .pm_counter(pm_counter),
      .timer_carry_irq_enable(timer_carry_irq_enable),
      .global_irq_enable(global_irq_enable),
      .bus_master_req(bus_master_req), .fw_attention(fw_attention),
      .fw_lock_release(fw_lock_release),
      .fw_lock_pending(fw_lock_pending),
      .enter_working_state(enter_working_state),
      .system_control_irq(system_control_irq));

   ////////////////////////////////////////////////////////////////
   // helpers
   task check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   // wait edges, then step just past the edge
   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc

   task rd(input logic w, input logic [15:0] a, input logic ea,
      input logic [15:0] ed);
      logic ack;
      logic [15:0] d;
      i_pm1_host_model.access(1'b1, 1'b0, w, a, 16'h0000, ack, d);
      check({15'h0000, ack}, {15'h0000, ea});
      check(d, ed);
   endtask : rd

   task wr(input logic w, input logic [15:0] a, input logic [15:0] v);
      logic ack;
      logic [15:0] d;
      i_pm1_host_model.access(1'b0, 1'b1, w, a, v, ack, d);
      check({15'h0000, ack}, 16'h0001);
   endtask : wr

   task close_out;
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // watchdog against a hung handshake
   initial
   begin
      #50000;
      n_errors++;
      close_out;
   end

   ////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {resetn, pm_counter, timer_carry_irq_enable, global_irq_enable,
       bus_master_req, fw_attention, enter_working_state,
       fw_lock_release, fw_lock_pending} = '0;
      cyc(1);
      check({14'h0000, io_ack, system_control_irq}, 16'h0000);
      check(io_rdata, 16'h0000);
      cyc(5);
      resetn = 1'b1;
      rd(1'b1, PA, 1'b1, 16'h0000);
      rd(1'b1, PB, 1'b1, 16'h0000);
      // raise all three events
      pm_counter[23] = 1'b1;
      bus_master_req = 1'b1;
      fw_attention = 1'b1;
      cyc(1);
      fw_attention = 1'b0;
      cyc(1);
      bus_master_req = 1'b0;
      cyc(4);
      check({15'h0, system_control_irq}, 16'h0);
      timer_carry_irq_enable = 1'b1;
      cyc(1);
      check({15'h0, system_control_irq}, 16'h1);
      {timer_carry_irq_enable, global_irq_enable} = 2'b01;
      cyc(1);
      check({15'h0, system_control_irq}, 16'h1);
      global_irq_enable = 1'b0;
      // placement, split and sizes
      foreach (rows[i])
         rd(rows[i].word, rows[i].addr, rows[i].ack, rows[i].data);
      // write-one-clear and ignored writes
      wr(1'b1, PA, 16'h0000);
      rd(1'b1, PA, 1'b1, 16'h0011);
      wr(1'b1, PB, 16'h0011);
      rd(1'b1, PA, 1'b1, 16'h0011);
      wr(1'b0, PA + 16'h0001, 16'h00ff);
      rd(1'b1, PA, 1'b1, 16'h0011);
      wr(1'b1, PA, 16'h0010);
      rd(1'b1, PA, 1'b1, 16'h0001);
      timer_carry_irq_enable = 1'b1;
      wr(1'b0, PA, 16'h0001);
      check({15'h0, system_control_irq}, 16'h0);
      wr(1'b1, PB, 16'h0020);
      rd(1'b1, PB, 1'b1, 16'h0000);
      // falling counter msb also sets the timer flag
      pm_counter = 24'h00_0000;
      cyc(2);
      check({15'h0, system_control_irq}, 16'h1);
      rd(1'b1, PA, 1'b1, 16'h0001);
      timer_carry_irq_enable = 1'b0;
      // lock release only sets with pending seen
      fw_lock_release = 1'b1;
      cyc(1);
      fw_lock_release = 1'b0;
      rd(1'b1, PB, 1'b1, 16'h0000);
      {fw_lock_release, fw_lock_pending} = 2'b11;
      cyc(1);
      {fw_lock_release, fw_lock_pending} = 2'b00;
      rd(1'b1, PB, 1'b1, 16'h0020);
      // attention with its enable on, then cleared by a one
      global_irq_enable = 1'b1;
      fw_attention = 1'b1;
      cyc(1);
      fw_attention = 1'b0;
      check({15'h0, system_control_irq}, 16'h1);
      wr(1'b0, PB, 16'h0020);
      check({15'h0, system_control_irq}, 16'h0);
      global_irq_enable = 1'b0;
      // entry to working state clears everything
      bus_master_req = 1'b1;
      cyc(4);
      // a clear in the cycle of a set loses
      wr(1'b1, PA, 16'h0010);
      rd(1'b1, PA, 1'b1, 16'h0011);
      bus_master_req = 1'b0;
      cyc(4);
      enter_working_state = 1'b1;
      cyc(1);
      enter_working_state = 1'b0;
      rd(1'b1, PA, 1'b1, 16'h0000);
      rd(1'b1, PB, 1'b1, 16'h0000);
      // reset in mid-run with the counter msb high
      pm_counter[23] = 1'b1;
      cyc(2);
      resetn = 1'b0;
      cyc(1);
      check({14'h0000, io_ack, system_control_irq}, 16'h0000);
      check(io_rdata, 16'h0000);
      resetn = 1'b1;
      rd(1'b1, PA, 1'b1, 16'h0000);
      close_out;
   end
endmodule : pm1_event_status_bank_tb_top
